/* File: sesel_pkg.sv */
`default_nettype none
package sesel_pkg;
    // serial command encodings
    localparam logic [7:0] SESEL_CMD_READ = 8'h03;
    localparam logic [7:0] SESEL_CMD_WRITE = 8'h02;
    localparam logic [7:0] SESEL_CMD_WREN = 8'h06;
    localparam logic [7:0] SESEL_CMD_WRDI = 8'h04;
    localparam logic [7:0] SESEL_CMD_RDSR = 8'h05;
    // address field
    localparam int SESEL_ADDR_BITS = 13;
    localparam int SESEL_MEM_WORDS = 8192;
    localparam int SESEL_PAGE_BITS = 5;
    localparam int SESEL_PAGE_BYTES = 32;
    localparam logic [4:0] SESEL_ADDR_PHASE_END = 5'h17;
    localparam logic [4:0] SESEL_CMD_PHASE_END = 5'h07;
    localparam logic [2:0] SESEL_BIT_LAST = 3'h7;
    // status bit positions
    localparam int SESEL_ST_BUSY = 0;
    localparam int SESEL_ST_WEN = 1;
    // timing
    localparam int SESEL_CLK_HZ = 20000000;
    localparam int SESEL_TWC_MS = 5;
    localparam int SESEL_TWC_CYC = SESEL_CLK_HZ / 1000 * SESEL_TWC_MS;

    typedef struct packed {
        logic sel_n;
        logic sck;
        logic sdi;
        logic pause_n;
    } sesel_pins_t;

    typedef struct packed {
        logic sdo;
        logic sdo_oe_n;
    } sesel_out_t;

    typedef enum logic [1:0] {
        SESEL_PH_CMD,
        SESEL_PH_ADDR,
        SESEL_PH_DATA,
        SESEL_PH_DEAD
    } sesel_phase_t;
endpackage : sesel_pkg
`default_nettype wire

/* File: sesel_mem.sv */
`default_nettype none
module sesel_mem
    import sesel_pkg::*;
(
    // clock
    input wire logic clk,
    input wire logic ce,
    // write port
    input wire logic wr_en,
    input wire logic [SESEL_ADDR_BITS-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read port
    input wire logic [SESEL_ADDR_BITS-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:SESEL_MEM_WORDS-1];
    logic [7:0] rd_data_r;

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data_r <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_r;
endmodule : sesel_mem
`default_nettype wire

/* File: sesel_top.sv */
// Overview of operation
// - serial traffic is taken only while chip select is low.
// - chip select high deselects, drops any sequence and enters standby unless programming.
// - a started programming cycle always runs to its end whatever chip select does.
// - with chip select high during programming, standby is entered only once it ends.
// - while deselected the serial output is released to high impedance.
// - programming starts on the chip select rise after a complete valid write.
// - after power-up nothing is taken until a falling chip select is seen.
// - read data bits change after the falling serial clock edge.
// - input bits are captured on the rising serial clock edge.
// - all bytes move most significant bit first.
// - pause low forces the serial output to high impedance two clock cycles later, once through the synchroniser.
`default_nettype none
module sesel_top
    import sesel_pkg::*;
#(
    parameter int TWC_CYC = SESEL_TWC_CYC
)
(
    // system
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    // serial pins
    input wire sesel_pins_t pins,
    output sesel_out_t sout,
    // state
    output logic standby,
    output logic busy
);
    // two-flop synchronisers on all pins
    sesel_pins_t s1_r, s2_r, s3_r;
    logic [2:0] warm_r;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1_r <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0, pause_n: 1'b1};
            s2_r <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0, pause_n: 1'b1};
            s3_r <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0, pause_n: 1'b1};
            warm_r <= 3'h0;
        end
        else if (ce)
        begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            warm_r <= {warm_r[1:0], 1'b1};
        end
    end

    logic sel, sel_fall, sel_rise, sck_rise, sck_fall, paused;
    assign sel = ~s2_r.sel_n;
    // select held low through reset must not read as a fall
    assign sel_fall = ~s2_r.sel_n & s3_r.sel_n & warm_r[2];
    assign sel_rise = s2_r.sel_n & ~s3_r.sel_n;
    assign paused = ~s2_r.pause_n;
    // edges while paused are ignored
    assign sck_rise = s2_r.sck & ~s3_r.sck & ~paused;
    assign sck_fall = ~s2_r.sck & s3_r.sck & ~paused;

    // serial sequence state
    sesel_phase_t phase_r, phase_nxt;
    logic armed_r, armed_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [SESEL_ADDR_BITS-1:0] addr_r, addr_nxt;
    logic [7:0] shin_r, shin_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] shout_r, shout_nxt;
    logic sdo_r, sdo_nxt;
    logic byte_done_r, byte_done_nxt;
    logic wen_r, wen_nxt;
    logic prog_r, prog_nxt;
    logic [$clog2(TWC_CYC+1)-1:0] twc_r, twc_nxt;
    logic [7:0] page_r [0:SESEL_PAGE_BYTES-1];
    logic [SESEL_PAGE_BYTES-1:0] pvalid_r, pvalid_nxt;
    logic [SESEL_PAGE_BITS-1:0] pidx_r, pidx_nxt;
    logic [SESEL_PAGE_BITS-1:0] flush_r, flush_nxt;
    logic pg_we;
    logic [7:0] rd_data;
    logic mem_we;
    logic [SESEL_ADDR_BITS-1:0] mem_wa;
    logic [7:0] status;

    assign status = {6'h00, wen_r, prog_r};

    always_comb
    begin
        phase_nxt = phase_r;
        armed_nxt = armed_r;
        cnt_nxt = cnt_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        shin_nxt = shin_r;
        bit_nxt = bit_r;
        shout_nxt = shout_r;
        sdo_nxt = sdo_r;
        byte_done_nxt = byte_done_r;
        wen_nxt = wen_r;
        prog_nxt = prog_r;
        twc_nxt = twc_r;
        pvalid_nxt = pvalid_r;
        pidx_nxt = pidx_r;
        flush_nxt = flush_r;
        pg_we = 1'b0;
        mem_we = 1'b0;
        mem_wa = {addr_r[SESEL_ADDR_BITS-1:SESEL_PAGE_BITS], flush_r};
        if (sel_fall)
        begin
            armed_nxt = 1'b1;
            phase_nxt = SESEL_PH_CMD;
            cnt_nxt = 5'h00;
            bit_nxt = 3'h0;
            byte_done_nxt = 1'b0;
            pvalid_nxt = prog_r ? pvalid_r : '0;
        end
        else if (sel_rise)
        begin
            phase_nxt = SESEL_PH_CMD;
            cnt_nxt = 5'h00;
            if (armed_r && !prog_r && phase_r == SESEL_PH_CMD && cnt_r == 5'h08)
            begin
                if (cmd_r == SESEL_CMD_WREN)
                    wen_nxt = 1'b1;
                if (cmd_r == SESEL_CMD_WRDI)
                    wen_nxt = 1'b0;
            end
            // only a whole last byte arms programming
            if (armed_r && !prog_r && wen_r && cmd_r == SESEL_CMD_WRITE
                && phase_r == SESEL_PH_DATA && byte_done_r && bit_r == 3'h0)
            begin
                prog_nxt = 1'b1;
                twc_nxt = '0;
                flush_nxt = '0;
            end
        end
        else if (sel && armed_r && sck_rise)
        begin
            shin_nxt = {shin_r[6:0], s2_r.sdi};
            unique case (phase_r)
                SESEL_PH_CMD:
                begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == SESEL_CMD_PHASE_END)
                    begin
                        cmd_nxt = {shin_r[6:0], s2_r.sdi};
                        if (cmd_nxt == SESEL_CMD_READ || cmd_nxt == SESEL_CMD_WRITE)
                            phase_nxt = SESEL_PH_ADDR;
                        else if (cmd_nxt == SESEL_CMD_RDSR)
                        begin
                            phase_nxt = SESEL_PH_DATA;
                            shout_nxt = status;
                            bit_nxt = 3'h0;
                        end
                    end
                    else if (cnt_r == 5'h08)
                        phase_nxt = SESEL_PH_DEAD;
                end
                SESEL_PH_ADDR:
                begin
                    cnt_nxt = cnt_r + 5'h01;
                    addr_nxt = {addr_r[SESEL_ADDR_BITS-2:0], s2_r.sdi};
                    if (cnt_r == SESEL_ADDR_PHASE_END)
                    begin
                        phase_nxt = SESEL_PH_DATA;
                        bit_nxt = 3'h0;
                        pidx_nxt = addr_nxt[SESEL_PAGE_BITS-1:0];
                    end
                end
                SESEL_PH_DATA:
                begin
                    bit_nxt = bit_r + 3'h1;
                    byte_done_nxt = (bit_r == SESEL_BIT_LAST);
                    if (bit_r == SESEL_BIT_LAST && cmd_r == SESEL_CMD_WRITE && !prog_r)
                    begin
                        pg_we = 1'b1;
                        pvalid_nxt[pidx_r] = 1'b1;
                        pidx_nxt = pidx_r + 5'h01; // page wrap
                    end
                    if (bit_r == SESEL_BIT_LAST && cmd_r == SESEL_CMD_READ)
                        addr_nxt = addr_r + 13'h0001;
                end
                SESEL_PH_DEAD:
                begin
                end
            endcase
        end
        else if (sel && armed_r && sck_fall && phase_r == SESEL_PH_DATA)
        begin
            if (bit_r == 3'h0)
            begin
                // memory read data already registered by the first fall
                shout_nxt = (cmd_r == SESEL_CMD_RDSR) ? status : rd_data;
                sdo_nxt = shout_nxt[7];
                shout_nxt = {shout_nxt[6:0], 1'b0};
            end
            else
            begin
                sdo_nxt = shout_r[7];
                shout_nxt = {shout_r[6:0], 1'b0};
            end
        end
        // programming runs independent of select
        if (prog_r)
        begin
            if (pvalid_r[flush_r])
                mem_we = 1'b1;
            if (flush_r != 5'h1f)
                flush_nxt = flush_r + 5'h01;
            twc_nxt = twc_r + 1'b1;
            if (twc_r == $bits(twc_r)'(TWC_CYC - 1))
            begin
                prog_nxt = 1'b0;
                wen_nxt = 1'b0;
                pvalid_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phase_r <= SESEL_PH_CMD;
            armed_r <= 1'b0;
            cnt_r <= 5'h00;
            cmd_r <= 8'h00;
            addr_r <= '0;
            shin_r <= 8'h00;
            bit_r <= 3'h0;
            shout_r <= 8'h00;
            sdo_r <= 1'b0;
            byte_done_r <= 1'b0;
            wen_r <= 1'b0;
            prog_r <= 1'b0;
            twc_r <= '0;
            pvalid_r <= '0;
            pidx_r <= '0;
            flush_r <= '0;
        end
        else if (ce)
        begin
            phase_r <= phase_nxt;
            armed_r <= armed_nxt;
            cnt_r <= cnt_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            shin_r <= shin_nxt;
            bit_r <= bit_nxt;
            shout_r <= shout_nxt;
            sdo_r <= sdo_nxt;
            byte_done_r <= byte_done_nxt;
            wen_r <= wen_nxt;
            prog_r <= prog_nxt;
            twc_r <= twc_nxt;
            pvalid_r <= pvalid_nxt;
            pidx_r <= pidx_nxt;
            flush_r <= flush_nxt;
        end
    end

    // page buffer: small and written one byte at a time
    always_ff @(posedge clk)
    begin
        if (ce && pg_we)
            page_r[pidx_r] <= shin_nxt;
    end

    sesel_mem u_mem (
        .clk(clk),
        .ce(ce),
        .wr_en(mem_we),
        .wr_addr(mem_wa),
        .wr_data(page_r[flush_r]),
        .rd_addr(addr_r),
        .rd_data(rd_data)
    );

    logic drive;
    // array reads are refused while programming
    assign drive = sel && armed_r && !paused && phase_r == SESEL_PH_DATA
        && (cmd_r == SESEL_CMD_RDSR || (cmd_r == SESEL_CMD_READ && !prog_r));
    assign sout.sdo = sdo_r;
    assign sout.sdo_oe_n = ~drive;
    assign standby = ~sel & ~prog_r;
    assign busy = prog_r;
endmodule : sesel_top
`default_nettype wire

/* File: sesel_top_assertions.sv */
`default_nettype none
module sesel_chk
    import sesel_pkg::*;
#(
    parameter int TWC_CYC = SESEL_TWC_CYC
)
(
    // system
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    // serial pins
    input wire sesel_pins_t pins,
    input wire sesel_out_t sout,
    // state
    input wire logic standby,
    input wire logic busy
);
    int cnt_r;
    int cnt_nxt;
    // a frozen clock enable stretches programming in clk cycles
    always_comb cnt_nxt = !ce ? cnt_r : (busy ? cnt_r + 1 : 0);
    always_ff @(posedge clk) cnt_r <= sys_rst ? 0 : cnt_nxt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !ce);
    a_sel_active: assert property (!pins.sel_n [*4] |-> !standby)
        else $error("standby while selected");
    a_idle_standby: assert property (pins.sel_n [*6] && !busy |-> standby)
        else $error("no standby when idle");
    a_busy_hold: assert property ($rose(busy) |=> busy [*8])
        else $error("programming cut short");
    a_busy_len: assert property ($fell(busy) |-> cnt_r == TWC_CYC)
        else $error("programming length wrong");
    a_busy_standby: assert property (busy |-> !standby)
        else $error("standby during programming");
    a_desel_hiz: assert property (pins.sel_n [*4] |-> sout.sdo_oe_n)
        else $error("output driven while deselected");
    a_busy_start: assert property ($rose(busy) |->
        $past(pins.sel_n) && !$past(pins.sel_n, 8))
        else $error("programming without select rise");
    a_sdo_fall: assert property (!sout.sdo_oe_n && !$past(sout.sdo_oe_n)
        && $changed(sout.sdo) |-> !$past(pins.sck, 2))
        else $error("output changed off falling clock");
    a_pause_hiz: assert property (!pins.pause_n [*4] |-> sout.sdo_oe_n)
        else $error("output driven while paused");
    cover property ($rose(busy));
    cover property (!sout.sdo_oe_n ##1 sout.sdo_oe_n);
    cover property ($fell(busy) && standby);
endmodule : sesel_chk
`default_nettype wire

/* File: sesel_host.sv */
`default_nettype none
module sesel_host
    import sesel_pkg::*;
(
    // system
    input wire logic clk,
    // serial pins
    output sesel_pins_t pins,
    input wire sesel_out_t sout
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_seen = 1'b0;
    // select low at power-up so the device starts unarmed
    initial pins = '{sel_n: 1'b0, sck: 1'b0, sdi: 1'b0, pause_n: 1'b1};
    // released data line toggles so a stale bit never looks like data
    always @(posedge clk) if (pins.sel_n) pins.sdi <= #1 ~pins.sdi;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic sel(input logic lvl);
        pins.sel_n = lvl;
        tick(4);
        pins.sck = 1'b0;
        tick(4);
    endtask : sel
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            pins.sck = 1'b0;
            pins.sdi = tx[i];
            tick(4);
            // released line shows the inverse so stale bits never pass
            rx[i] = sout.sdo_oe_n ? ~sout.sdo : sout.sdo;
            drv_seen |= !sout.sdo_oe_n;
            pins.sck = 1'b1;
            tick(4);
        end
    endtask : xfer
endmodule : sesel_host
`default_nettype wire

/* File: sesel_top_tb_top.sv */
`default_nettype none
module sesel_top_tb_top
    import sesel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // long enough that a read frame fits inside one programming cycle
    localparam int TWC = 400;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    sesel_pins_t pins;
    sesel_out_t sout;
    logic standby;
    logic busy;
    logic [7:0] d;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    sesel_host u_sesel_host (.clk(clk), .pins(pins), .sout(sout));
    sesel_top #(.TWC_CYC(TWC)) u_sesel_top (.clk(clk), .ce(ce), .sys_rst(sys_rst),
        .pins(pins), .sout(sout), .standby(standby), .busy(busy));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic rd_frame(input logic [15:0] a);
        u_sesel_host.drv_seen = 1'b0;
        u_sesel_host.xfer(SESEL_CMD_READ, d);
        u_sesel_host.xfer(a[15:8], d);
        u_sesel_host.xfer(a[7:0], d);
    endtask : rd_frame
    task automatic t_unarmed;
        rd_frame(16'h0010);
        u_sesel_host.xfer(8'hff, d);
        chk("drive unarmed", 8'h00, {7'h0, u_sesel_host.drv_seen});
        u_sesel_host.sel(1'b1);
        chk("oe_n idle", 8'h01, {7'h0, sout.sdo_oe_n});
        chk("standby idle", 8'h01, {7'h0, standby});
        $display("test unarmed done");
    endtask : t_unarmed
    task automatic t_write;
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_WREN, d);
        u_sesel_host.sel(1'b1);
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_WRITE, d);
        u_sesel_host.xfer(8'h00, d);
        u_sesel_host.xfer(8'h10, d);
        u_sesel_host.xfer(8'ha5, d);
        u_sesel_host.sel(1'b1);
        chk("busy start", 8'h01, {7'h0, busy});
        chk("standby busy", 8'h00, {7'h0, standby});
        u_sesel_host.sel(1'b0);
        rd_frame(16'h0010);
        u_sesel_host.xfer(8'hff, d);
        chk("read refused", 8'h00, {7'h0, u_sesel_host.drv_seen});
        u_sesel_host.sel(1'b1);
        chk("busy kept", 8'h01, {7'h0, busy});
        for (int n = 0; n < 200 && busy === 1'b1; n++)
            u_sesel_host.tick(1);
        chk("standby after", 8'h01, {7'h0, standby});
        $display("test write done");
    endtask : t_write
    task automatic t_read;
        u_sesel_host.sel(1'b0);
        rd_frame(16'h0010);
        chk("hiz in address", 8'h00, {7'h0, u_sesel_host.drv_seen});
        u_sesel_host.xfer(8'hff, d);
        chk("read data", 8'ha5, d);
        u_sesel_host.pins.pause_n = 1'b0;
        u_sesel_host.tick(4);
        chk("oe_n paused", 8'h01, {7'h0, sout.sdo_oe_n});
        u_sesel_host.pins.pause_n = 1'b1;
        u_sesel_host.sel(1'b1);
        $display("test read done");
    endtask : t_read
    task automatic t_abort;
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_WREN, d);
        u_sesel_host.sel(1'b1);
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_WRITE, d);
        u_sesel_host.xfer(8'h00, d);
        u_sesel_host.sel(1'b1);
        u_sesel_host.tick(8);
        chk("no program", 8'h00, {7'h0, busy});
        $display("test abort done");
    endtask : t_abort
    task automatic rd_status(output logic [7:0] st);
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_RDSR, d);
        u_sesel_host.xfer(8'hff, st);
        u_sesel_host.sel(1'b1);
    endtask : rd_status
    task automatic t_status;
        rd_status(d);
        chk("status wen", 8'(1 << SESEL_ST_WEN), d);
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_WRDI, d);
        u_sesel_host.sel(1'b1);
        rd_status(d);
        chk("status clear", 8'h00, d);
        // a frozen block must miss the whole command
        ce = 1'b0;
        u_sesel_host.sel(1'b0);
        u_sesel_host.xfer(SESEL_CMD_RDSR, d);
        ce = 1'b1;
        u_sesel_host.drv_seen = 1'b0;
        u_sesel_host.xfer(8'hff, d);
        chk("frozen command", 8'h00, {7'h0, u_sesel_host.drv_seen});
        u_sesel_host.sel(1'b1);
        $display("test status done");
    endtask : t_status
    initial
    begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_unarmed();
        t_write();
        t_read();
        t_abort();
        t_status();
        end_sim();
    end
endmodule : sesel_top_tb_top
bind sesel_top sesel_chk #(.TWC_CYC(TWC_CYC)) u_sesel_chk (.clk(clk), .ce(ce),
    .sys_rst(sys_rst), .pins(pins), .sout(sout), .standby(standby), .busy(busy));
`default_nettype wire
